// ===== mag_regs_defines.vh
// constants for the magnetometer data, status and power register slice
// assumes a serial front end that turns host frames into byte accesses
// Behaviour
// R1 - y_field_high_byte returns y bits 12..5, y msb at bit 7
// R2 - z_field_low_and_selftest bits 7..1 hold z bits 6..0
// R3 - z_field_low_and_selftest bit 0 is z self-test flag, one after reset
// R4 - z_field_high_byte holds z bits 14..7, top bit at bit 7
// R5 - hall_res_low_and_ready bits 7..2 hold hall bits 5..0, bit 1 reads zero
// R6 - hall_res_high_byte holds hall bits 13..6, top bit at bit 7
// R7 - hall_res_low_and_ready bit 0 shows new sample ready
// R8 - interrupt_flags flags: overrun, overflow, high z/y/x, low z/y/x
// R9 - power_reset_wire_ctrl stays readable and writable in suspend
// R10 - soft reset only when bits 7 and 1 both written one
// R11 - soft reset clears all but power register, no full power-on
// R12 - finished soft reset always lands in sleep mode; here only if the power bit is still one when it ends
// R13 - soft reset ignored in suspend, device stays suspended
// R14 - both trigger bits self-clear when soft reset finishes
// R15 - host does suspend then sleep for a full power-on reset
// R16 - power_reset_wire_ctrl bit 2 one selects three-wire, zero four-wire
// R17 - power_reset_wire_ctrl bit 0 one gives sleep, zero gives suspend
// R18 - latched interrupt stays on until interrupt_flags is read
`ifndef MAG_REGS_DEFINES_VH
`define MAG_REGS_DEFINES_VH

`define ADDR_Y_UPPER        8'h45
`define ADDR_Z_LOWER        8'h46
`define ADDR_Z_UPPER        8'h47
`define ADDR_HALL_LOWER     8'h48
`define ADDR_HALL_UPPER     8'h49
`define ADDR_INT_FLAGS      8'h4a
`define ADDR_POWER_CTRL     8'h4b

`define POWER_RESET         8'h01
`define POWER_BIT_ON        0
`define POWER_BIT_SRST_LO   1
`define POWER_BIT_WIRE      2
`define POWER_BIT_SRST_HI   7

`define Y_WIDTH             13
`define Z_WIDTH             15
`define HALL_WIDTH          14
`define FLAG_WIDTH          8
`define SELFTEST_RESET      1'b1

`define CLK_PERIOD_NS       40
`define SRST_TIME_NS        1000
`define SRST_CYCLES         ((`SRST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== soft_reset_seq.v
// soft reset sequencer: counts out the reset time after a start pulse
// assumes start is a one-cycle pulse, ignored while a sequence runs
`timescale 1ns/1ps
`include "mag_regs_defines.vh"

module soft_reset_seq
#(
    parameter CYCLES = `SRST_CYCLES,
    parameter CW     = 16
)
(
    input  wire          core_clk,
    input  wire          rst_n,
    input  wire          start,
    output reg           busy,
    output reg           done
);

    reg  [CW-1:0]        count;

    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            busy  <= 1'b0;
            done  <= 1'b0;
            count <= {CW{1'b0}};
        end
        else
        begin
            done <= 1'b0;
            if (!busy && start)
            begin
                busy  <= 1'b1;
                count <= CYCLES[CW-1:0];
            end
            else if (busy)
            begin
                if (count <= {{(CW-1){1'b0}}, 1'b1})
                begin
                    busy  <= 1'b0;
                    done  <= 1'b1;
                    count <= {CW{1'b0}};
                end
                else
                begin
                    count <= count - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // soft_reset_seq

// ===== mag_data_status_power_regs.v
// register slice y_field_high_byte..power_reset_wire_ctrl: y/z field, hall resistance, status, power
// assumes a serial front end giving byte reads and writes, and a
// measurement core giving samples and interrupt conditions on core_clk
`timescale 1ns/1ps
`include "mag_regs_defines.vh"

module mag_data_status_power_regs
#(
    parameter SRST_CYCLES = `SRST_CYCLES
)
(
    input  wire                     core_clk,
    input  wire                     rst_n,
    input  wire [7:0]               regAddr,
    input  wire                     regWrite,
    input  wire                     regRead,
    input  wire [7:0]               regWrData,
    output reg  [7:0]               regRdData,
    output reg                      regRdValid,
    input  wire                     sampleValid,
    input  wire [`Y_WIDTH-1:0]      yField,
    input  wire [`Z_WIDTH-1:0]      zField,
    input  wire [`HALL_WIDTH-1:0]   hallRes,
    input  wire                     zSelftestIn,
    input  wire [`FLAG_WIDTH-1:0]   intEvents,
    input  wire                     intLatchMode,
    output wire                     intActive,
    output reg                      powerOn,
    output reg                      threeWireSelect,
    output wire                     softResetBusy,
    output reg                      sleepRequest,
    output reg                      powerOnReset
);

    // stored sample and status
    reg  [`Y_WIDTH-1:0]      yStore;
    reg  [`Z_WIDTH-1:0]      zStore;
    reg  [`HALL_WIDTH-1:0]   hallStore;
    reg                      zSelftest;
    reg                      newSampleFlag;
    reg  [`FLAG_WIDTH-1:0]   intFlags;
    reg                      srstTrigHi;
    reg                      srstTrigLo;
    reg                      powerOnPrev;

    // decoded accesses
    wire                     wrPower;
    wire                     rdFlags;
    wire                     rdHallLower;
    wire                     srstRequest;
    wire                     srstStart;
    wire                     srstDone;
    wire                     clearContent;
    wire                     captureSample;
    reg  [7:0]               next_rdData;

    // one read word per register except interrupt_flags, which reads intFlags directly, packed as the host sees it
    wire [7:0]               yUpperWord;
    wire [7:0]               zLowerWord;
    wire [7:0]               zUpperWord;
    wire [7:0]               hallLowerWord;
    wire [7:0]               hallUpperWord;
    wire [7:0]               powerWord;

    // power register default, taken apart bit by bit below
    localparam [7:0]         PWR_DEFAULT = `POWER_RESET;

    // true when addr hits reg and the slice may answer in this power state
    function hit;
        input [7:0] addr;
        input [7:0] reg_addr;
        input       on;
        begin
            hit = (addr == reg_addr) &&
                  (on || (reg_addr == `ADDR_POWER_CTRL));
        end
    endfunction

    assign wrPower     = regWrite && hit(regAddr, `ADDR_POWER_CTRL, powerOn);
    assign rdFlags     = regRead && hit(regAddr, `ADDR_INT_FLAGS, powerOn);
    assign rdHallLower = regRead && hit(regAddr, `ADDR_HALL_LOWER, powerOn);

    // trigger needs both bits in one write, and only outside suspend
    assign srstRequest = wrPower &&
                         regWrData[`POWER_BIT_SRST_HI] &&
                         regWrData[`POWER_BIT_SRST_LO];          // see R10
    assign srstStart   = srstRequest && powerOn &&
                         regWrData[`POWER_BIT_ON];               // see R13

    soft_reset_seq
    #(
        .CYCLES (SRST_CYCLES),
        .CW     (16)
    )
    u_srst
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (srstStart),
        .busy     (softResetBusy),
        .done     (srstDone)
    );

    // content clears on soft reset end and is held cleared in suspend,
    // so waking from suspend starts from power-on defaults
    assign clearContent  = srstDone || !powerOn;                 // see R11
    assign captureSample = sampleValid && powerOn && !softResetBusy;

    // power bit; written in any power state
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            powerOn <= PWR_DEFAULT[`POWER_BIT_ON];
        end
        else if (wrPower)
        begin
            powerOn <= regWrData[`POWER_BIT_ON];                 // see R17
        end
    end

    // wire mode survives a soft reset, it belongs to the power register
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            threeWireSelect <= PWR_DEFAULT[`POWER_BIT_WIRE];
        end
        else if (wrPower)
        begin
            threeWireSelect <= regWrData[`POWER_BIT_WIRE];       // see R16
        end
    end

    // trigger bits read back as one while the sequence runs
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            srstTrigHi <= PWR_DEFAULT[`POWER_BIT_SRST_HI];
            srstTrigLo <= PWR_DEFAULT[`POWER_BIT_SRST_LO];
        end
        else if (srstStart)
        begin
            srstTrigHi <= 1'b1;
            srstTrigLo <= 1'b1;
        end
        else if (srstDone)
        begin
            srstTrigHi <= 1'b0;                                  // see R14
            srstTrigLo <= 1'b0;                                  // see R14
        end
    end

    // sleep is requested after a soft reset unless suspend was written meanwhile; the power bit stays as written
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            sleepRequest <= 1'b0;
        end
        else
        begin
            sleepRequest <= srstDone && powerOn;                 // see R12
        end
    end

    // a wake from suspend is a full power-on, flagged for one cycle
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            powerOnPrev  <= 1'b0;
            powerOnReset <= 1'b0;
        end
        else
        begin
            powerOnPrev  <= powerOn;
            powerOnReset <= powerOn && !powerOnPrev;
        end
    end

    // measurement data, kept whole so a later read sees one sample;
    // content is zero after reset, soft reset end and in suspend
    always @(posedge core_clk)
    begin
        if (!rst_n || clearContent)
        begin
            yStore <= {`Y_WIDTH{1'b0}};                          // see R11
        end
        else if (captureSample)
        begin
            yStore <= yField;
        end
    end

    always @(posedge core_clk)
    begin
        if (!rst_n || clearContent)
        begin
            zStore <= {`Z_WIDTH{1'b0}};                          // see R11
        end
        else if (captureSample)
        begin
            zStore <= zField;
        end
    end

    always @(posedge core_clk)
    begin
        if (!rst_n || clearContent)
        begin
            hallStore <= {`HALL_WIDTH{1'b0}};                    // see R11
        end
        else if (captureSample)
        begin
            hallStore <= hallRes;
        end
    end

    // self-test flag comes back as one after any reset
    always @(posedge core_clk)
    begin
        if (!rst_n || clearContent)
        begin
            zSelftest <= `SELFTEST_RESET;                        // see R3
        end
        else if (captureSample)
        begin
            zSelftest <= zSelftestIn;
        end
    end

    // new sample flag: set wins over the read that clears it
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            newSampleFlag <= 1'b0;
        end
        else if (clearContent)
        begin
            newSampleFlag <= 1'b0;
        end
        else if (captureSample)
        begin
            newSampleFlag <= 1'b1;                               // see R7
        end
        else if (rdHallLower)
        begin
            newSampleFlag <= 1'b0;
        end
    end

    // interrupt flags, latched or following the live condition
    genvar i;
    generate
        for (i = 0; i < `FLAG_WIDTH; i = i + 1)
        begin : g_flag
            always @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    intFlags[i] <= 1'b0;
                end
                else if (clearContent)
                begin
                    intFlags[i] <= 1'b0;
                end
                else if (!intLatchMode)
                begin
                    intFlags[i] <= intEvents[i];
                end
                else if (intEvents[i])
                begin
                    intFlags[i] <= 1'b1;                         // see R8
                end
                else if (rdFlags)
                begin
                    // a new event in the read cycle is kept
                    intFlags[i] <= 1'b0;                         // see R18
                end
            end
        end
    endgenerate

    // pin polarity and pin enable live outside this slice
    assign intActive = |intFlags;                                // see R18

    assign yUpperWord    = yStore[12:5];                         // see R1
    assign zLowerWord    = {zStore[6:0], zSelftest};             // see R2
    assign zUpperWord    = zStore[14:7];                         // see R4
    assign hallLowerWord = {hallStore[5:0], 1'b0, newSampleFlag}; // see R5
    assign hallUpperWord = hallStore[13:6];                      // see R6
    assign powerWord     = {srstTrigHi, 4'h0, threeWireSelect,
                            srstTrigLo, powerOn};                // see R9

    // read mux; in suspend only the power register answers
    always @*
    begin
        next_rdData = 8'h00;
        if (hit(regAddr, `ADDR_Y_UPPER, powerOn))
        begin
            next_rdData = yUpperWord;
        end
        else if (hit(regAddr, `ADDR_Z_LOWER, powerOn))
        begin
            next_rdData = zLowerWord;
        end
        else if (hit(regAddr, `ADDR_Z_UPPER, powerOn))
        begin
            next_rdData = zUpperWord;
        end
        else if (hit(regAddr, `ADDR_HALL_LOWER, powerOn))
        begin
            next_rdData = hallLowerWord;
        end
        else if (hit(regAddr, `ADDR_HALL_UPPER, powerOn))
        begin
            next_rdData = hallUpperWord;
        end
        else if (hit(regAddr, `ADDR_INT_FLAGS, powerOn))
        begin
            next_rdData = intFlags;                              // see R8
        end
        else if (hit(regAddr, `ADDR_POWER_CTRL, powerOn))
        begin
            next_rdData = powerWord;                             // see R9
        end
    end

    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRead;
            if (regRead)
            begin
                regRdData <= next_rdData;
            end
        end
    end

endmodule // mag_data_status_power_regs

// ===== mag_regs_checker_assertions.sv
// assertions on the register slice ports
// assumes binding to mag_data_status_power_regs, sync reset
`timescale 1ns/1ps
module mag_regs_checker
#(
    parameter SRST_CYCLES = 25
)
(
    input wire       core_clk,
    input wire       rst_n,
    input wire [7:0] regAddr,
    input wire       regWrite,
    input wire       regRead,
    input wire [7:0] regWrData,
    input wire       regRdValid,
    input wire       intLatchMode,
    input wire       intActive,
    input wire       powerOn,
    input wire       threeWireSelect,
    input wire       softResetBusy,
    input wire       sleepRequest,
    input wire       powerOnReset
);
    reg  [7:0] busyCnt;
    wire       wrCtl = regWrite && regAddr == 8'h4b;
    wire       trig = wrCtl && regWrData[7] && regWrData[1];
    wire       rdFlags = regRead && regAddr == 8'h4a;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    always @(posedge core_clk)
        busyCnt <= (!rst_n || !softResetBusy) ? 8'h00 : busyCnt + 8'h01;
    a_read_answers: assert property (regRead |=> regRdValid)
        else $error("read not answered");
    a_srst_starts: assert property
        (trig && regWrData[0] && powerOn && !softResetBusy |=> softResetBusy)
        else $error("soft reset did not start");
    a_srst_needs_both: assert property
        (wrCtl && !trig && !softResetBusy |=> !softResetBusy)
        else $error("soft reset from one bit");
    a_suspend_no_srst: assert property
        (!powerOn && !softResetBusy |=> !softResetBusy)
        else $error("soft reset in suspend");
    a_srst_length: assert property
        ($fell(softResetBusy) |-> busyCnt == SRST_CYCLES)
        else $error("soft reset length wrong");
    a_srst_to_sleep: assert property
        ($fell(softResetBusy) |-> ##[0:1] (sleepRequest && powerOn))
        else $error("soft reset did not end in sleep");
    a_wire_written: assert property
        (wrCtl |=> threeWireSelect == $past(regWrData[2]))
        else $error("wire mode not written");
    a_power_written: assert property
        (wrCtl && !softResetBusy && !sleepRequest |=>
            powerOn == $past(regWrData[0]))
        else $error("power bit not written");
    a_wake_por: assert property ($rose(powerOn) |=> powerOnReset)
        else $error("no power-on reset on wake");
    a_latched_holds: assert property
        (intLatchMode && intActive && powerOn && !softResetBusy &&
            !$fell(softResetBusy) && !regWrite && !rdFlags |=> intActive)
        else $error("latched interrupt dropped");
    c_srst: cover property ($fell(softResetBusy));
    c_wake: cover property ($rose(powerOn));
    c_flag_read: cover property (rdFlags && intActive);
endmodule // mag_regs_checker
bind mag_data_status_power_regs mag_regs_checker
    #(.SRST_CYCLES(SRST_CYCLES)) chk (.core_clk, .rst_n, .regAddr,
    .regWrite, .regRead, .regWrData, .regRdValid, .intLatchMode, .intActive,
    .powerOn, .threeWireSelect, .softResetBusy, .sleepRequest, .powerOnReset);

// ===== mag_host_model.sv
// host model: byte reads and writes on the register port
// assumes read data arrives one cycle after the strobe is taken
`timescale 1ns/1ps
module mag_host_model
(
    input  wire       core_clk,
    input  wire [7:0] regRdData,
    input  wire       regRdValid,
    output reg  [7:0] regAddr = 8'h00,
    output reg        regWrite = 1'b0,
    output reg        regRead = 1'b0,
    output reg  [7:0] regWrData = 8'h00
);
    // released lines show the inverse so stale values never match
    task wr(input [7:0] a, input [7:0] v);
    begin
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~v;
    end
    endtask
    task rd(input [7:0] a, output [7:0] v);
    begin
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(posedge core_clk);
        v = (regRdValid === 1'b1) ? regRdData : 8'hxx;
    end
    endtask
endmodule // mag_host_model

// ===== mag_data_status_power_regs_tb.sv
// self-checking bench for the magnetometer register slice
// assumes the host model drives the register port
`timescale 1ns/1ps
`include "mag_regs_defines.vh"
module mag_data_status_power_regs_tb;
    localparam [12:0] Y = 13'h1a5c;
    localparam [14:0] Z = 15'h5a3c;
    localparam [13:0] H = 14'h2b71;
    reg                    core_clk = 1'b0;
    reg                    rst_n = 1'b0;
    reg                    sampleValid = 1'b0;
    reg  [`Y_WIDTH-1:0]    yField = 13'h0000;
    reg  [`Z_WIDTH-1:0]    zField = 15'h0000;
    reg  [`HALL_WIDTH-1:0] hallRes = 14'h0000;
    reg                    zSelftestIn = 1'b1;
    reg  [7:0]             intEvents = 8'h00;
    reg                    intLatchMode = 1'b1;
    wire [7:0]             regAddr, regWrData, regRdData;
    wire                   regWrite, regRead, regRdValid, intActive;
    wire                   powerOn, threeWireSelect, softResetBusy;
    wire                   sleepRequest, powerOnReset;
    integer                mismatches = 0;
    integer                samples_checked = 0;
    integer                cycles = 0;
    reg  [7:0]             d;
    always #20 core_clk = ~core_clk;
    mag_host_model host (.core_clk(core_clk), .regRdData(regRdData),
        .regRdValid(regRdValid), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWrData(regWrData));
    mag_data_status_power_regs #(.SRST_CYCLES(3)) uut (.core_clk(core_clk),
        .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .sampleValid(sampleValid), .yField(yField),
        .zField(zField), .hallRes(hallRes), .zSelftestIn(zSelftestIn),
        .intEvents(intEvents), .intLatchMode(intLatchMode),
        .intActive(intActive), .powerOn(powerOn),
        .threeWireSelect(threeWireSelect), .softResetBusy(softResetBusy),
        .sleepRequest(sleepRequest), .powerOnReset(powerOnReset));
    task check(input string what, input [7:0] seen, input [7:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task rdChk(input [7:0] a, input [7:0] exp);
    begin
        host.rd(a, d);
        check("read data", d, exp);
    end
    endtask
    task pushSample;
    begin
        @(posedge core_clk);
        sampleValid <= 1'b1;
        {yField, zField, hallRes, zSelftestIn} <= {Y, Z, H, 1'b0};
        @(posedge core_clk);
        sampleValid <= 1'b0;
    end
    endtask
    task tSample;
    begin
        rdChk(8'h46, 8'h01);
        pushSample;
        rdChk(8'h45, Y[12:5]);
        rdChk(8'h46, {Z[6:0], 1'b0});
        rdChk(8'h47, Z[14:7]);
        rdChk(8'h48, {H[5:0], 2'b01});
        rdChk(8'h49, H[13:6]);
        rdChk(8'h48, {H[5:0], 2'b00});
        rdChk(8'h50, 8'h00);
        $display("sample test done");
    end
    endtask
    task tFlags;
        integer i;
    begin
        for (i = 0; i < 2; i = i + 1)
        begin
            @(posedge core_clk);
            intEvents <= i ? 8'h5a : 8'ha5;
            @(posedge core_clk);
            intEvents <= 8'h00;
            @(posedge core_clk);
            check("intActive", intActive, 8'h01);
            rdChk(8'h4a, i ? 8'h5a : 8'ha5);
            rdChk(8'h4a, 8'h00);
        end
        @(posedge core_clk);
        intLatchMode <= 1'b0;
        intEvents <= 8'h81;
        @(posedge core_clk);
        intEvents <= 8'h00;
        @(posedge core_clk);
        check("intActive", intActive, 8'h01);
        @(posedge core_clk);
        check("intActive", intActive, 8'h00);
        intLatchMode <= 1'b1;
        $display("flag test done");
    end
    endtask
    task tSoftReset;
        integer n;
    begin
        host.wr(8'h4b, 8'h05);
        rdChk(8'h4b, 8'h05);
        check("threeWireSelect", threeWireSelect, 8'h01);
        pushSample;
        host.wr(8'h4b, 8'h87);
        @(posedge core_clk);
        check("softResetBusy", softResetBusy, 8'h01);
        for (n = 0; n < 40 && softResetBusy !== 1'b0; n = n + 1)
            @(posedge core_clk);
        rdChk(8'h4b, 8'h05);
        rdChk(8'h45, 8'h00);
        check("powerOn", powerOn, 8'h01);
        $display("soft reset test done");
    end
    endtask
    task tSuspend;
    begin
        pushSample;
        host.wr(8'h4b, 8'h00);
        rdChk(8'h45, 8'h00);
        host.wr(8'h4b, 8'h86);
        @(posedge core_clk);
        check("softResetBusy", softResetBusy, 8'h00);
        host.wr(8'h4b, 8'h04);
        rdChk(8'h4b, 8'h04);
        host.wr(8'h4b, 8'h01);
        rdChk(8'h46, 8'h01);
        check("powerOn", powerOn, 8'h01);
        $display("suspend test done");
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches = mismatches + 1;
            end_of_test;
        end
    end
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        tSample;
        tFlags;
        tSoftReset;
        tSuspend;
        end_of_test;
    end
endmodule // mag_data_status_power_regs_tb
